//--- hw/umc_pkg.sv
// Constants, register map and types for the modem control line block.
// Assumes one clk_sys domain and a plain single-cycle register port.
// Function
// RL1 - Port send-request output low when control bit 1 is one.
// RL2 - Hardware reset drives both send-request outputs high.
// RL3 - Loop mode holds send-request output high regardless of control.
// RL4 - Port 2 send-request pin level latched at reset release as base strap.
// RL5 - Port terminal-ready output low when control bit 0 is one.
// RL6 - Hardware reset drives both terminal-ready outputs high.
// RL7 - Loop mode holds terminal-ready output high regardless of control.
// RL8 - Status bit 4 is inverted clear-to-send; rising pin sets bit 0.
// RL9 - Clear-to-send never affects transmission; status and interrupt only.
// RL10 - Status bit 5 is inverted set-ready; rising pin sets bit 1.
// RL11 - Status bit 7 is inverted carrier-detect; rising pin sets bit 3.
// RL12 - Status bit 6 is inverted ring; rising pin sets bit 2.
// RL13 - Enable bit 3 set raises port interrupt on any status input change.
// RL14 - Status read clears change bits 0 to 3 and pending interrupt.
// RL15 - Status inputs synchronised first so one transition counts once.
package umc_pkg;
   localparam int          ADDR_W       = 5;
   localparam int          DATA_W       = 8;
   localparam int          NUM_PORTS    = 2;
   localparam int          NUM_LINES    = 4;
   // Register offsets; IER, MCR and MSR repeat one stride above for the second port
   localparam logic [4:0]  OFF_IER      = 5'h01;
   localparam logic [4:0]  OFF_MCR      = 5'h04;
   localparam logic [4:0]  OFF_MSR      = 5'h06;
   localparam logic [4:0]  PORT_STRIDE  = 5'h08;
   localparam logic [4:0]  OFF_INT_STAT = 5'h10;
   localparam logic [4:0]  OFF_INT_MASK = 5'h11;
   localparam logic [4:0]  OFF_STRAP    = 5'h12;
   // Field positions
   localparam int          MCR_DTR_BIT  = 0;
   localparam int          MCR_RTS_BIT  = 1;
   localparam int          MCR_LOOP_BIT = 4;
   localparam int          IER_MS_BIT   = 3;
   // Reset values
   localparam logic [4:0]  MCR_RST      = 5'h00;
   localparam logic [3:0]  IER_RST      = 4'h0;
   localparam logic [1:0]  INT_RST      = 2'h0;
   localparam logic [7:0]  SYNC_RST     = 8'hFF;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } umc_bus_req_t;

   // Line order matches the change bits 3..0 of the status register
   typedef struct packed {
      logic dcd;
      logic ri;
      logic dsr;
      logic cts;
   } umc_modem_in_t;
endpackage : umc_pkg

//--- hw/umc_modem_lines.sv
// Modem handshake outputs, status inputs and base strap for two ports.
// Assumes asynchronous modem pins and a register master on clk_sys.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
module umc_modem_lines (
   input  wire logic                  clk_sys,
   input  wire logic                  reset,
   input  wire umc_pkg::umc_bus_req_t regReq,
   output logic [7:0]                 regRdata,
   input  wire logic                  clear_to_send_port1_n,
   input  wire logic                  clear_to_send_port2_n,
   input  wire logic                  set_ready_port1_n,
   input  wire logic                  set_ready_port2_n,
   input  wire logic                  carrier_detect_port1_n,
   input  wire logic                  carrier_detect_port2_n,
   input  wire logic                  ring_detect_port1_n,
   input  wire logic                  ring_detect_port2_n,
   input  wire logic                  sendRequestPort2In,
   output logic                       send_request_port1_n,
   output logic                       send_request_port2_n,
   output logic                       sendRequestPort2OeN,
   output logic                       terminal_ready_port1_n,
   output logic                       terminal_ready_port2_n,
   output logic [1:0]                 portIrq,
   output logic                       irq,
   output logic                       config_base_strap
);
   localparam int NP = umc_pkg::NUM_PORTS;
   localparam int NL = umc_pkg::NUM_LINES;

   function automatic logic [4:0] portAddr(input int p,
                                           input logic [4:0] off);
      portAddr = off + (p[0] ? umc_pkg::PORT_STRIDE : 5'h00);
   endfunction : portAddr

   // Loop mode wins over the control bit
   function automatic logic ctrlLevel(input logic [4:0] modem_control_reg,
                                      input int b);
      ctrlLevel = ~(modem_control_reg[b] & ~modem_control_reg[umc_pkg::MCR_LOOP_BIT]);
   endfunction : ctrlLevel

   umc_pkg::umc_modem_in_t  port1In;
   umc_pkg::umc_modem_in_t  port2In;
   logic [7:0]              syncA_r;
   logic [7:0]              syncB_r;
   logic [7:0]              syncC_r;
   logic [7:0]              stable_r;
   logic [7:0]              settled;
   logic [7:0]              rise;
   logic [7:0]              chg;
   logic [4:0]              mcr_r    [NP];
   logic [4:0]              mcrNxt   [NP];
   logic [3:0]              ier_r    [NP];
   logic [3:0]              delta_r  [NP];
   logic [NP-1:0]           pend_r;
   logic [NP-1:0]           pendNxt;
   logic [NP-1:0]           msRead;
   logic [NP-1:0]           intStat_r;
   logic [NP-1:0]           intStatNxt;
   logic [NP-1:0]           intMask_r;
   logic [7:0]              rdNxt;
   logic                    resetD_r;
   logic                    strapA_r;
   logic                    strapB_r;
   logic                    strapC_r;

   assign port1In = '{dcd: carrier_detect_port1_n, ri: ring_detect_port1_n,
                      dsr: set_ready_port1_n, cts: clear_to_send_port1_n};
   assign port2In = '{dcd: carrier_detect_port2_n, ri: ring_detect_port2_n,
                      dsr: set_ready_port2_n, cts: clear_to_send_port2_n};

   // Three-stage synchroniser; first stage feeds only the second
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         syncA_r  <= umc_pkg::SYNC_RST;
         syncB_r  <= umc_pkg::SYNC_RST;
         syncC_r  <= umc_pkg::SYNC_RST;
         stable_r <= umc_pkg::SYNC_RST;
      end else begin
         syncA_r  <= {port2In, port1In}; // RL15
         syncB_r  <= syncA_r;
         syncC_r  <= syncB_r;
         for (int i = 0; i < 8; i++) begin
            if (settled[i]) begin
               stable_r[i] <= syncC_r[i]; // RL15
            end
         end
      end
   end

   always_comb begin
      settled = ~(syncB_r ^ syncC_r);
      rise    = settled & syncC_r & ~stable_r;
      chg     = settled & (syncC_r ^ stable_r);
   end

   always_comb begin
      for (int p = 0; p < NP; p++) begin
         mcrNxt[p] = mcr_r[p];
         if (regReq.wr && regReq.addr == portAddr(p, umc_pkg::OFF_MCR)) begin
            mcrNxt[p] = regReq.wdata[4:0];
         end
         msRead[p]  = regReq.rd
                      && regReq.addr == portAddr(p, umc_pkg::OFF_MSR);
         pendNxt[p] = (msRead[p] ? 1'b0 : pend_r[p]) | (|chg[p*NL +: NL]);
      end
   end

   // Control and enable registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         for (int p = 0; p < NP; p++) begin
            mcr_r[p] <= umc_pkg::MCR_RST;
            ier_r[p] <= umc_pkg::IER_RST;
         end
      end else begin
         for (int p = 0; p < NP; p++) begin
            mcr_r[p] <= mcrNxt[p];
            if (regReq.wr
                && regReq.addr == portAddr(p, umc_pkg::OFF_IER)) begin
               ier_r[p] <= regReq.wdata[3:0];
            end
         end
      end
   end

   // Outputs follow the control value of the same edge
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         send_request_port1_n   <= 1'b1; // RL2
         send_request_port2_n   <= 1'b1; // RL2
         terminal_ready_port1_n <= 1'b1; // RL6
         terminal_ready_port2_n <= 1'b1; // RL6
      end else begin
         send_request_port1_n   <= ctrlLevel(mcrNxt[0],
                                             umc_pkg::MCR_RTS_BIT); // RL1 RL3
         send_request_port2_n   <= ctrlLevel(mcrNxt[1],
                                             umc_pkg::MCR_RTS_BIT); // RL1 RL3
         terminal_ready_port1_n <= ctrlLevel(mcrNxt[0],
                                             umc_pkg::MCR_DTR_BIT); // RL5 RL7
         terminal_ready_port2_n <= ctrlLevel(mcrNxt[1],
                                             umc_pkg::MCR_DTR_BIT); // RL5 RL7
      end
   end

   // Change flags: a rise in the read cycle survives the clear
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         for (int p = 0; p < NP; p++) begin
            delta_r[p] <= 4'h0;
         end
         pend_r  <= '0;
         portIrq <= '0;
      end else begin
         for (int p = 0; p < NP; p++) begin
            delta_r[p] <= (msRead[p] ? 4'h0 : delta_r[p])
                          | rise[p*NL +: NL]; // RL8 RL10 RL11 RL12 RL14
            portIrq[p] <= pendNxt[p] & ier_r[p][umc_pkg::IER_MS_BIT]; // RL13
         end
         pend_r <= pendNxt; // RL14
      end
   end

   // Sticky event bits, write one to clear, set wins
   always_comb begin
      intStatNxt = intStat_r;
      if (regReq.wr && regReq.addr == umc_pkg::OFF_INT_STAT) begin
         intStatNxt = intStat_r & ~regReq.wdata[NP-1:0];
      end
      for (int p = 0; p < NP; p++) begin
         intStatNxt[p] = intStatNxt[p] | (|chg[p*NL +: NL]);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         intStat_r <= umc_pkg::INT_RST;
         intMask_r <= umc_pkg::INT_RST;
         irq       <= 1'b0;
      end else begin
         intStat_r <= intStatNxt;
         if (regReq.wr && regReq.addr == umc_pkg::OFF_INT_MASK) begin
            intMask_r <= regReq.wdata[NP-1:0];
         end
         irq <= |(intStatNxt & intMask_r);
      end
   end

   // Read mux; status shows the inverted pins above the change flags
   always_comb begin
      rdNxt = 8'h00;
      for (int p = 0; p < NP; p++) begin
         if (regReq.addr == portAddr(p, umc_pkg::OFF_IER)) begin
            rdNxt = {4'h0, ier_r[p]};
         end
         if (regReq.addr == portAddr(p, umc_pkg::OFF_MCR)) begin
            rdNxt = {3'h0, mcr_r[p]};
         end
         if (regReq.addr == portAddr(p, umc_pkg::OFF_MSR)) begin
            rdNxt = {~stable_r[p*NL +: NL], delta_r[p]}; // RL8 RL10 RL11 RL12
         end
      end
      if (regReq.addr == umc_pkg::OFF_INT_STAT) begin
         rdNxt = {6'h00, intStat_r};
      end
      if (regReq.addr == umc_pkg::OFF_INT_MASK) begin
         rdNxt = {6'h00, intMask_r};
      end
      if (regReq.addr == umc_pkg::OFF_STRAP) begin
         rdNxt = {7'h00, config_base_strap};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         regRdata <= 8'h00;
      end else begin
         regRdata <= regReq.rd ? rdNxt : 8'h00;
      end
   end

   // Strap sampler is left unreset so it fills while reset is held
   always_ff @(posedge clk_sys) begin
      strapA_r <= sendRequestPort2In;
      strapB_r <= strapA_r;
      strapC_r <= strapB_r;
   end

   // Pin is released during reset so the board level can be seen
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         resetD_r            <= 1'b1;
         sendRequestPort2OeN <= 1'b1;
         config_base_strap   <= 1'b0;
      end else begin
         resetD_r <= 1'b0;
         if (resetD_r) begin
            config_base_strap   <= strapC_r; // RL4
            sendRequestPort2OeN <= 1'b0;
         end
      end
   end

   // Clear-to-send feeds only status and interrupt logic

   a_rts_on_write: assert property (@(posedge clk_sys) // RL1
      disable iff (reset)
      regReq.wr && regReq.addr == umc_pkg::OFF_MCR && regReq.wdata[1]
      && !regReq.wdata[4] |=> !send_request_port1_n)
      else $error("send request not asserted after control write");
   a_rts2_on_write: assert property (@(posedge clk_sys) // RL1
      disable iff (reset)
      regReq.wr && regReq.addr == portAddr(1, umc_pkg::OFF_MCR)
      && regReq.wdata[1] && !regReq.wdata[4] |=> !send_request_port2_n)
      else $error("port 2 send request not asserted after control write");
   a_outs_in_reset: assert property (@(posedge clk_sys) // RL2 RL6
      reset |=> send_request_port1_n && send_request_port2_n
      && terminal_ready_port1_n && terminal_ready_port2_n)
      else $error("handshake outputs not inactive after reset");
   a_loop_rts_high: assert property (@(posedge clk_sys) // RL3
      disable iff (reset)
      mcr_r[1][umc_pkg::MCR_LOOP_BIT] |-> send_request_port2_n)
      else $error("send request active in loop mode");
   a_strap_latch: assert property (@(posedge clk_sys) // RL4
      disable iff (reset)
      $fell(reset) |=> config_base_strap == $past(strapC_r)
      && !sendRequestPort2OeN)
      else $error("strap not latched at reset release");
   a_strap_release: assert property (@(posedge clk_sys) // RL4
      reset |=> sendRequestPort2OeN)
      else $error("send request pin driven during reset");
   a_dtr_on_write: assert property (@(posedge clk_sys) // RL5
      disable iff (reset)
      regReq.wr && regReq.addr == portAddr(1, umc_pkg::OFF_MCR)
      && regReq.wdata[0] && !regReq.wdata[4] |=> !terminal_ready_port2_n)
      else $error("terminal ready not asserted after control write");
   a_loop_dtr_high: assert property (@(posedge clk_sys) // RL7
      disable iff (reset)
      mcr_r[0][umc_pkg::MCR_LOOP_BIT] |-> terminal_ready_port1_n)
      else $error("terminal ready active in loop mode");
   a_cts_no_gate: assert property (@(posedge clk_sys) // RL9
      disable iff (reset)
      $changed(stable_r[0]) && !regReq.wr
      |=> $stable(send_request_port1_n) && $stable(terminal_ready_port1_n))
      else $error("clear-to-send change moved a handshake output");
   a_cts_delta_set: assert property (@(posedge clk_sys) // RL8
      disable iff (reset)
      rise[0] |=> delta_r[0][0] ##0 !rise[0])
      else $error("clear-to-send change flag missed");
   a_dsr_delta_set: assert property (@(posedge clk_sys) // RL10
      disable iff (reset)
      rise[5] |=> delta_r[1][1])
      else $error("set-ready change flag missed");
   a_dcd_delta_set: assert property (@(posedge clk_sys) // RL11
      disable iff (reset)
      rise[3] |=> delta_r[0][3])
      else $error("carrier change flag missed");
   a_ri_delta_set: assert property (@(posedge clk_sys) // RL12
      disable iff (reset)
      rise[6] |=> delta_r[1][2])
      else $error("ring change flag missed");
   a_port_irq_raise: assert property (@(posedge clk_sys) // RL13
      disable iff (reset)
      (|chg[3:0]) && ier_r[0][umc_pkg::IER_MS_BIT] |=> portIrq[0])
      else $error("port interrupt not raised on line change");
   a_read_clears: assert property (@(posedge clk_sys) // RL14
      disable iff (reset)
      msRead[0] && !(|chg[3:0]) |=> delta_r[0] == 4'h0 && !portIrq[0])
      else $error("status read did not clear flags");
   a_sync_delay: assert property (@(posedge clk_sys) // RL15
      disable iff (reset)
      $changed(syncB_r[1]) |-> !chg[1])
      else $error("change counted before stages agree");
   a_chg_once: assert property (@(posedge clk_sys) // RL15
      disable iff (reset)
      chg[1] |=> !chg[1])
      else $error("one line change counted twice");
endmodule : umc_modem_lines

//--- dv/umc_modem_model.sv
// Behavioural modem on the far side of both ports, plus the board pull
// on the port 2 send-request pin.
// Assumes the bench calls its tasks; modem pins idle high until told.
`timescale 1ns/1ns
module umc_modem_model (
   input  wire logic       clk_sys,
   output logic [7:0]      modemPinN,
   output logic            strapLevel
);
   // Strap level is left to setStrap so time zero holds no race
   initial begin
      modemPinN  = 8'hFF;
   end

   // Zero lag answers at once; a longer lag models a slow modem
   task automatic drive(input int idx, input logic lvl, input int lag);
      repeat (lag) @(posedge clk_sys);
      modemPinN[idx] <= lvl;
   endtask : drive

   // Pull must stand for the whole reset so it is seen as reset ends
   task automatic setStrap(input logic s);
      strapLevel = s;
   endtask : setStrap
endmodule : umc_modem_model

//--- dv/test_uart_modem_control_lines.sv
// Self-checking bench for the modem line block: register tasks drive the
// plain port, the modem model drives status pins and the strap pull.
// Assumes one clk_sys domain and synchronous active-high reset.
`timescale 1ns/1ns
module test_uart_modem_control_lines;
   logic                  clk_sys     = 1'b0;
   logic                  reset       = 1'b1;
   umc_pkg::umc_bus_req_t req         = '0;
   logic [7:0]            regRdata;
   logic [7:0]            pinN;
   logic                  strapLevel;
   logic                  sendRequestPort2In;
   logic [1:0]            sendN;
   logic [1:0]            termN;
   logic [1:0]            portIrq;
   logic                  oeN;
   logic                  irq;
   logic                  strap;
   int                    miscompares = 0;
   int                    n_checks    = 0;

   always #4 clk_sys = ~clk_sys;
   // Board pull shows on the pin only while the port leaves it undriven
   assign sendRequestPort2In = oeN ? strapLevel : sendN[1];

   umc_modem_model i_modem (.clk_sys(clk_sys), .modemPinN(pinN),
      .strapLevel(strapLevel));

   umc_modem_lines i_dut (.clk_sys(clk_sys), .reset(reset), .regReq(req),
      .regRdata(regRdata),
      .clear_to_send_port1_n(pinN[0]), .set_ready_port1_n(pinN[1]),
      .ring_detect_port1_n(pinN[2]), .carrier_detect_port1_n(pinN[3]),
      .clear_to_send_port2_n(pinN[4]), .set_ready_port2_n(pinN[5]),
      .ring_detect_port2_n(pinN[6]), .carrier_detect_port2_n(pinN[7]),
      .sendRequestPort2In(sendRequestPort2In),
      .send_request_port1_n(sendN[0]), .send_request_port2_n(sendN[1]),
      .sendRequestPort2OeN(oeN),
      .terminal_ready_port1_n(termN[0]), .terminal_ready_port2_n(termN[1]),
      .portIrq(portIrq), .irq(irq), .config_base_strap(strap));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      req.addr  <= a;
      req.wdata <= d;
      req.wr    <= 1'b1;
      @(posedge clk_sys);
      req.wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      req.addr <= a;
      req.rd   <= 1'b1;
      @(posedge clk_sys);
      req.rd <= 1'b0;
      #1;
      chk(regRdata, exp);
   endtask : rd

   function automatic logic [4:0] pa(input logic [4:0] off, input int p);
      return off + ((p == 1) ? umc_pkg::PORT_STRIDE : 5'h00);
   endfunction : pa

   task automatic results;
      if (miscompares == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results

   task automatic doReset(input logic s);
      i_modem.setStrap(s);
      @(posedge clk_sys);
      reset <= 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      chk({4'h0, sendN, termN}, 8'h0F);
      chk({7'h00, oeN}, 8'h01);
      @(posedge clk_sys);
      reset <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      chk({7'h00, strap}, {7'h00, s});
      chk({7'h00, oeN}, 8'h00);
      rd(umc_pkg::OFF_STRAP, {7'h00, s});
      wr(umc_pkg::OFF_STRAP, {7'h00, ~s});
      rd(umc_pkg::OFF_STRAP, {7'h00, s});
   endtask : doReset

   initial begin
      doReset(1'b0);
      doReset(1'b1);
      rd(5'h1F, 8'h00);
      for (int p = 0; p < 2; p++) begin
         for (int v = 0; v < 4; v++) begin
            wr(pa(umc_pkg::OFF_MCR, p), 8'(v));
            chk({6'h00, sendN[p], termN[p]}, {6'h00, ~v[1:0]});
            wr(pa(umc_pkg::OFF_MCR, p), 8'(v) | 8'h10);
            chk({6'h00, sendN[p], termN[p]}, 8'h03);
            rd(pa(umc_pkg::OFF_MCR, p), 8'(v) | 8'h10);
         end
         wr(pa(umc_pkg::OFF_MCR, p), 8'h03);
         wr(pa(umc_pkg::OFF_IER, p), 8'h08);
         rd(pa(umc_pkg::OFF_IER, p), 8'h08);
      end
      // Only port 0 reaches the shared line, so port 1 proves the mask
      wr(umc_pkg::OFF_INT_MASK, 8'h01);
      rd(umc_pkg::OFF_INT_MASK, 8'h01);
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 4; i++) begin
            i_modem.drive(4 * p + i, 1'b0, p);
            repeat (6) @(posedge clk_sys);
            #1;
            chk({6'h00, portIrq}, 8'(1 << p));
            chk({7'h00, irq}, {7'h00, p == 0});
            rd(pa(umc_pkg::OFF_MSR, p), 8'h10 << i);
            rd(umc_pkg::OFF_INT_STAT, 8'(1 << p));
            chk({6'h00, portIrq}, 8'h00);
            wr(umc_pkg::OFF_INT_STAT, 8'(1 << p));
            repeat (2) @(posedge clk_sys);
            #1;
            chk({7'h00, irq}, 8'h00);
            i_modem.drive(4 * p + i, 1'b1, 0);
            repeat (6) @(posedge clk_sys);
            #1;
            chk({6'h00, portIrq}, 8'(1 << p));
            rd(pa(umc_pkg::OFF_MSR, p), 8'h01 << i);
            rd(pa(umc_pkg::OFF_MSR, p), 8'h00);
            wr(umc_pkg::OFF_INT_STAT, 8'(1 << p));
            chk({4'h0, sendN, termN}, 8'h00);
         end
      end
      wr(pa(umc_pkg::OFF_IER, 0), 8'h00);
      i_modem.drive(0, 1'b0, 0);
      repeat (6) @(posedge clk_sys);
      #1;
      chk({6'h00, portIrq}, 8'h00);
      rd(pa(umc_pkg::OFF_MSR, 0), 8'h10);
      results();
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      results();
   end
endmodule : test_uart_modem_control_lines
